// file: hdl/blsfm_liu_status.v
// LIU fault status, latched events, interrupt and framer mode registers
//
// Notes on behaviour
// - Live open bit is 1 while transmit outputs are sensed open.
// - Live short bit is 1 while transmit outputs are shorted, about 25 ohms.
// - Live absent bit is 1 while receiver sees loss of signal.
// - Receive pulse level reads at bits 7:4 in 2.5 dB steps.
// - Bits 6,5,4 latch on falling edge of open, short, absent.
// - Bits 2,1,0 latch on rising edge of open, short, absent.
// - A latched bit clears only when written with a one.
// - Interrupt request is high while any enabled latched bit is set.
// - Enable bits sit at the same positions as their latched bits.
// - Receive framer is low power when its enable bit is zero.
// - Receiver starts only after init done, and only if enabled.
// - Receive framer is held in reset while soft reset bit is one.
// - Receive line type zero selects T1, one selects E1.
// - Transmit formatter is low power when its enable bit is zero.
// - Transmit formatter is held in reset while soft reset is one.
// - Transmit line type zero selects T1, one selects E1.
// - Sync needs 10 framing bits when bit 7 is zero, else 24.
// - Each zero-to-one of the reframe bit requests one resync while the receiver runs in T1 mode.
// - Auto reframe runs when its off bit is zero.
// - Search rule bit picks SF cross-couple or ESF CRC6 check.
`default_nettype none
`include "blsfm_defs.vh"
module blsfm_liu_status (
   input wire core_clk,
   input wire sys_rst,
   input wire clkEn,
   input wire [7:0] cpuAddr,
   input wire cpuWrEn,
   input wire cpuRdEn,
   input wire [7:0] cpuWrData,
   output reg [7:0] cpuRdData,
   output reg cpuRdValid,
   input wire txOpenDet,
   input wire txShortDet,
   input wire rxAbsentDet,
   input wire rxFailDet,
   input wire rxOverEqDet,
   input wire rxUnderEqDet,
   input wire [3:0] rxLevelIn,
   output reg interruptRequestPin,
   output wire rxLowPower,
   output wire rxInReset,
   output wire rxRunning,
   output wire rxE1Mode,
   output wire txLowPower,
   output wire txInReset,
   output wire txRunning,
   output wire txE1Mode,
   output reg [4:0] frameQualCount,
   output reg frameSearchRule,
   output reg autoReframeOn,
   output reg rxReframePulse,
   output reg rxZeroSubstOn,
   output reg rxSfMode,
   output reg rxResyncOofOnly,
   output reg rxJapanCrcOn
);

   // Set wins over clear so an edge in the clearing cycle is kept
   function [7:0] w1cNext;
      input [7:0] cur;
      input [7:0] setBits;
      input [7:0] clrBits;
      begin
         w1cNext = (cur & ~clrBits) | setBits;
      end
   endfunction

   function wrHit;
      input [7:0] addr;
      input [7:0] target;
      input wr;
      begin
         wrHit = wr && (addr == target);
      end
   endfunction

   reg [7:0] live_q;
   reg [3:0] level_q;
   reg [7:0] latch_q;
   reg [7:0] latch_d;
   reg [7:0] irqEn_q;
   reg [7:0] rxMode_q;
   reg [7:0] txMode_q;
   reg [7:0] rxCfg_q;
   reg reframePrev_q;
   reg [7:0] setBits;
   reg [7:0] clrBits;
   reg [7:0] rdMux;
   wire wrLatch;
   wire wrIrqEn;
   wire wrRxMode;
   wire wrTxMode;
   wire wrRxCfg;
   wire [7:0] liveNow;

   assign wrLatch = wrHit(cpuAddr, `BLSFM_ADDR_LATCH, cpuWrEn);
   assign wrIrqEn = wrHit(cpuAddr, `BLSFM_ADDR_IRQEN, cpuWrEn);
   assign wrRxMode = wrHit(cpuAddr, `BLSFM_ADDR_RXMM, cpuWrEn);
   assign wrTxMode = wrHit(cpuAddr, `BLSFM_ADDR_TXMM, cpuWrEn);
   assign wrRxCfg = wrHit(cpuAddr, `BLSFM_ADDR_RXCFG1, cpuWrEn);

   // Detector levels are taken as synchronous, one flop of staging
   assign liveNow = {1'b0, rxFailDet, rxOverEqDet, rxUnderEqDet,
                     1'b0, txOpenDet, txShortDet, rxAbsentDet};

   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         live_q <= `BLSFM_RST_VAL;
         level_q <= 4'h0;
      end else if (clkEn) begin
         live_q <= liveNow & `BLSFM_LIVE_MASK;
         level_q <= rxLevelIn;
      end
   end

   // Edge capture compares the new live value against the stored one
   always @* begin
      setBits = 8'h00;
      setBits[`BLSFM_B_OPEN] = liveNow[`BLSFM_B_OPEN] &
         !live_q[`BLSFM_B_OPEN];
      setBits[`BLSFM_B_SHORT] = liveNow[`BLSFM_B_SHORT] &
         !live_q[`BLSFM_B_SHORT];
      setBits[`BLSFM_B_ABSENT] = liveNow[`BLSFM_B_ABSENT] &
         !live_q[`BLSFM_B_ABSENT];
      setBits[`BLSFM_B_OPEN + `BLSFM_CLR_OFS] =
         !liveNow[`BLSFM_B_OPEN] & live_q[`BLSFM_B_OPEN];
      setBits[`BLSFM_B_SHORT + `BLSFM_CLR_OFS] =
         !liveNow[`BLSFM_B_SHORT] & live_q[`BLSFM_B_SHORT];
      setBits[`BLSFM_B_ABSENT + `BLSFM_CLR_OFS] =
         !liveNow[`BLSFM_B_ABSENT] & live_q[`BLSFM_B_ABSENT];
      clrBits = wrLatch ? (cpuWrData & `BLSFM_LATCH_MASK) : 8'h00;
      latch_d = w1cNext(latch_q, setBits, clrBits) & `BLSFM_LATCH_MASK;
   end

   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         latch_q <= `BLSFM_RST_VAL;
         irqEn_q <= `BLSFM_RST_VAL;
         rxMode_q <= `BLSFM_RST_VAL;
         txMode_q <= `BLSFM_RST_VAL;
         rxCfg_q <= `BLSFM_RST_VAL;
      end else if (clkEn) begin
         latch_q <= latch_d;
         if (wrIrqEn) begin
            irqEn_q <= cpuWrData & `BLSFM_LATCH_MASK;
         end
         if (wrRxMode) begin
            rxMode_q <= cpuWrData & `BLSFM_MM_MASK;
         end
         if (wrTxMode) begin
            txMode_q <= cpuWrData & `BLSFM_MM_MASK;
         end
         // Stored and driven out in either mode; only the reframe edge waits for DS1 run
         if (wrRxCfg) begin
            rxCfg_q <= cpuWrData;
         end
      end
   end

   // Registered pin so it cannot glitch on the mask write
   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         interruptRequestPin <= 1'b0;
      end else if (clkEn) begin
         interruptRequestPin <= |(latch_d & irqEn_q);
      end
   end

   always @* begin
      case (cpuAddr)
         `BLSFM_ADDR_LIVE: begin
            rdMux = live_q;
         end
         `BLSFM_ADDR_LEVEL: begin
            rdMux = {level_q, 4'h0};
         end
         `BLSFM_ADDR_LATCH: begin
            rdMux = latch_q;
         end
         `BLSFM_ADDR_IRQEN: begin
            rdMux = irqEn_q;
         end
         `BLSFM_ADDR_RXMM: begin
            rdMux = rxMode_q;
         end
         `BLSFM_ADDR_TXMM: begin
            rdMux = txMode_q;
         end
         `BLSFM_ADDR_RXCFG1: begin
            rdMux = rxCfg_q;
         end
         default: begin
            rdMux = 8'h00;
         end
      endcase
   end

   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cpuRdData <= 8'h00;
         cpuRdValid <= 1'b0;
      end else if (clkEn) begin
         cpuRdValid <= cpuRdEn;
         if (cpuRdEn) begin
            cpuRdData <= rdMux;
         end
      end
   end

   blsfm_chan_ctl rxCtl (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .clkEn(clkEn),
      .enableBit(rxMode_q[`BLSFM_MM_ON]),
      .initDoneBit(rxMode_q[`BLSFM_MM_INIT]),
      .softResetBit(rxMode_q[`BLSFM_MM_SRST]),
      .lineTypeBit(rxMode_q[`BLSFM_MM_TYPE]),
      .lowPower(rxLowPower),
      .inReset(rxInReset),
      .running(rxRunning),
      .e1Mode(rxE1Mode)
   );

   blsfm_chan_ctl txCtl (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .clkEn(clkEn),
      .enableBit(txMode_q[`BLSFM_MM_ON]),
      .initDoneBit(txMode_q[`BLSFM_MM_INIT]),
      .softResetBit(txMode_q[`BLSFM_MM_SRST]),
      .lineTypeBit(txMode_q[`BLSFM_MM_TYPE]),
      .lowPower(txLowPower),
      .inReset(txInReset),
      .running(txRunning),
      .e1Mode(txE1Mode)
   );

   // DS1 receive controls; the reframe edge is only honoured in DS1 run
   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         reframePrev_q <= 1'b0;
         rxReframePulse <= 1'b0;
         frameQualCount <= `BLSFM_QUAL_SHORT;
         frameSearchRule <= 1'b0;
         autoReframeOn <= 1'b1;
         rxZeroSubstOn <= 1'b0;
         rxSfMode <= 1'b0;
         rxResyncOofOnly <= 1'b0;
         rxJapanCrcOn <= 1'b0;
      end else if (clkEn) begin
         reframePrev_q <= rxCfg_q[`BLSFM_C_REFRAME];
         rxReframePulse <= rxCfg_q[`BLSFM_C_REFRAME] & !reframePrev_q &
            rxRunning & !rxE1Mode;
         frameQualCount <= rxCfg_q[`BLSFM_C_QUAL] ? `BLSFM_QUAL_LONG :
            `BLSFM_QUAL_SHORT;
         frameSearchRule <= rxCfg_q[`BLSFM_C_RULE];
         autoReframeOn <= !rxCfg_q[`BLSFM_C_NOAUTO];
         rxZeroSubstOn <= rxCfg_q[`BLSFM_C_ZSUB];
         rxSfMode <= rxCfg_q[`BLSFM_C_SFMODE];
         rxResyncOofOnly <= rxCfg_q[`BLSFM_C_OOFONLY];
         rxJapanCrcOn <= rxCfg_q[`BLSFM_C_JCRC];
      end
   end

endmodule
`default_nettype wire

// file: common/blsfm_defs.vh
// Register map, field positions and reset values of the LIU status block
`ifndef BLSFM_DEFS_VH
`define BLSFM_DEFS_VH

`define BLSFM_ADDR_LIVE 8'h18
`define BLSFM_ADDR_LEVEL 8'h19
`define BLSFM_ADDR_LATCH 8'h1A
`define BLSFM_ADDR_IRQEN 8'h1B
`define BLSFM_ADDR_RXMM 8'h20
`define BLSFM_ADDR_TXMM 8'h21
`define BLSFM_ADDR_RXCFG1 8'h22

`define BLSFM_RST_VAL 8'h00
`define BLSFM_LATCH_MASK 8'h77
`define BLSFM_LIVE_MASK 8'h77
`define BLSFM_MM_MASK 8'hC3
`define BLSFM_LEVEL_MASK 8'hF0

// Live and latched bit positions
`define BLSFM_B_OPEN 2
`define BLSFM_B_SHORT 1
`define BLSFM_B_ABSENT 0
`define BLSFM_B_RXFAIL 6
`define BLSFM_B_OVEREQ 5
`define BLSFM_B_UNDEREQ 4
`define BLSFM_CLR_OFS 4
`define BLSFM_LEVEL_LSB 4

// Master mode fields
`define BLSFM_MM_ON 7
`define BLSFM_MM_INIT 6
`define BLSFM_MM_SRST 1
`define BLSFM_MM_TYPE 0

// DS1 receive configuration fields
`define BLSFM_C_QUAL 7
`define BLSFM_C_ZSUB 6
`define BLSFM_C_SFMODE 5
`define BLSFM_C_OOFONLY 4
`define BLSFM_C_RULE 3
`define BLSFM_C_JCRC 2
`define BLSFM_C_NOAUTO 1
`define BLSFM_C_REFRAME 0

`define BLSFM_QUAL_SHORT 5'h0A
`define BLSFM_QUAL_LONG 5'h18

`endif

// file: hdl/blsfm_chan_ctl.v
// Enable, init-done and soft-reset sequencing for one framer direction
`default_nettype none
module blsfm_chan_ctl (
   input wire core_clk,
   input wire sys_rst,
   input wire clkEn,
   input wire enableBit,
   input wire initDoneBit,
   input wire softResetBit,
   input wire lineTypeBit,
   output reg lowPower,
   output reg inReset,
   output reg running,
   output reg e1Mode
);
   localparam ST_OFF = 2'b00;
   localparam ST_RST = 2'b01;
   localparam ST_WAIT = 2'b10;
   localparam ST_RUN = 2'b11;

   reg [1:0] state_q;
   reg [1:0] state_d;

   always @* begin
      state_d = state_q;
      if (softResetBit) begin
         state_d = ST_RST;
      end else begin
         case (state_q)
            ST_OFF: begin
               if (enableBit) state_d = ST_WAIT;
            end
            ST_RST: begin
               state_d = enableBit ? ST_WAIT : ST_OFF;
            end
            ST_WAIT: begin
               if (!enableBit) state_d = ST_OFF;
               else if (initDoneBit) state_d = ST_RUN;
            end
            ST_RUN: begin
               if (!enableBit) state_d = ST_OFF;
               else if (!initDoneBit) state_d = ST_WAIT;
            end
            default: begin
               state_d = ST_OFF;
            end
         endcase
      end
   end

   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_q <= ST_OFF;
         lowPower <= 1'b1;
         inReset <= 1'b0;
         running <= 1'b0;
         e1Mode <= 1'b0;
      end else if (clkEn) begin
         state_q <= state_d;
         lowPower <= !enableBit;
         inReset <= (state_d == ST_RST);
         running <= (state_d == ST_RUN);
         e1Mode <= lineTypeBit;
      end
   end
endmodule
`default_nettype wire

// file: sim/blsfm_liu_status_assertions.sv
// Checker of the register port and framer mode outputs
`default_nettype none
module blsfm_liu_status_assertions (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic clkEn,
   input wire logic [7:0] cpuAddr,
   input wire logic cpuWrEn,
   input wire logic cpuRdEn,
   input wire logic [7:0] cpuWrData,
   input wire logic [7:0] cpuRdData,
   input wire logic rxLowPower,
   input wire logic rxInReset,
   input wire logic rxRunning,
   input wire logic rxE1Mode,
   input wire logic txLowPower,
   input wire logic txInReset,
   input wire logic txRunning,
   input wire logic txE1Mode,
   input wire logic [4:0] frameQualCount,
   input wire logic rxReframePulse
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);
   a_level_low: assert property (
      clkEn && cpuRdEn && cpuAddr == 8'h19 |=> cpuRdData[3:0] == 4'h0)
      else $error("level low nibble set");
   a_enable_map: assert property (
      clkEn && cpuRdEn && cpuAddr == 8'h1B |=> (cpuRdData & 8'h88) == 8'h00)
      else $error("enable reserved bit set");
   a_rx_mode: assert property (
      clkEn && cpuWrEn && cpuAddr == 8'h20 && !cpuWrData[1] ##1 clkEn
      |=> rxE1Mode == $past(cpuWrData[0], 2)
      && rxLowPower != $past(cpuWrData[7], 2))
      else $error("rx mode wrong");
   a_tx_mode: assert property (
      clkEn && cpuWrEn && cpuAddr == 8'h21 && !cpuWrData[1] ##1 clkEn
      |=> txE1Mode == $past(cpuWrData[0], 2)
      && txLowPower != $past(cpuWrData[7], 2))
      else $error("tx mode wrong");
   a_rx_hold: assert property (
      clkEn && cpuWrEn && cpuAddr == 8'h20 && cpuWrData[1] ##1 clkEn
      |=> rxInReset && !rxRunning)
      else $error("rx not held in reset");
   a_tx_hold: assert property (
      clkEn && cpuWrEn && cpuAddr == 8'h21 && cpuWrData[1] ##1 clkEn
      |=> txInReset && !txRunning)
      else $error("tx not held in reset");
   a_run_gate: assert property (
      !(rxRunning && (rxLowPower || rxInReset))
      && !(txRunning && (txLowPower || txInReset)))
      else $error("running while off");
   a_qual_count: assert property (
      clkEn && cpuWrEn && cpuAddr == 8'h22 ##1 clkEn
      |=> frameQualCount == ($past(cpuWrData[7], 2) ? 5'h18 : 5'h0A))
      else $error("qualify count wrong");
   a_reframe_once: assert property (
      rxReframePulse && clkEn |=> !rxReframePulse)
      else $error("reframe pulse too long");
endmodule
bind blsfm_liu_status blsfm_liu_status_assertions i_chk (.core_clk,
   .sys_rst, .clkEn, .cpuAddr, .cpuWrEn, .cpuRdEn, .cpuWrData, .cpuRdData,
   .rxLowPower, .rxInReset, .rxRunning, .rxE1Mode, .txLowPower, .txInReset,
   .txRunning, .txE1Mode, .frameQualCount, .rxReframePulse);
`default_nettype wire

// file: sim/blsfm_host.sv
// Host processor model driving the register strobe port
`default_nettype none
module blsfm_host (
   input wire logic core_clk,
   input wire logic [7:0] cpuRdData,
   input wire logic cpuRdValid,
   output logic [7:0] cpuAddr = 8'h00,
   output logic cpuWrEn = 1'b0,
   output logic cpuRdEn = 1'b0,
   output logic [7:0] cpuWrData = 8'h00
);
   timeunit 1ns;
   timeprecision 1ps;
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      cpuAddr <= a;
      cpuWrData <= d;
      cpuWrEn <= 1'b1;
      @(posedge core_clk);
      cpuWrEn <= 1'b0;
      // Stale data must not look valid after the strobe
      cpuWrData <= ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d,
      output logic v);
      @(posedge core_clk);
      cpuAddr <= a;
      cpuRdEn <= 1'b1;
      @(posedge core_clk);
      cpuRdEn <= 1'b0;
      #1;
      d = cpuRdData;
      v = cpuRdValid;
   endtask
endmodule
`default_nettype wire

// file: sim/blsfm_liu_status_tb.sv
// Self-checking bench of the LIU status and framer mode registers
`default_nettype none
module blsfm_liu_status_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic clkEn = 1'b1;
   logic [5:0] det = 6'h00;
   logic [3:0] lvl = 4'h0;
   wire [7:0] cpuAddr, cpuWrData, cpuRdData;
   wire cpuWrEn, cpuRdEn, cpuRdValid, irq, rule, autoOn, reframe;
   wire [3:0] rxS, txS;
   wire [4:0] qual;
   wire [3:0] misc;
   logic [7:0] got;
   logic [7:0] mWr [6] = '{8'h81, 8'hC1, 8'hC3, 8'hC1, 8'hC0, 8'h40};
   logic [3:0] mExp [6] = '{4'h1, 4'h3, 4'h5, 4'h3, 4'h2, 4'h8};
   logic [7:0] rstAddr [8] = '{8'h18, 8'h19, 8'h1A, 8'h1B, 8'h20, 8'h21,
      8'h22, 8'h30};
   int fails = 0;
   int n_tests = 0;
   int pulses = 0;
   int p0;
   always #5 core_clk = ~core_clk;
   always @(posedge core_clk) if (reframe === 1'b1) pulses++;
   blsfm_host i_blsfm_host (.core_clk(core_clk), .cpuRdData(cpuRdData),
      .cpuRdValid(cpuRdValid), .cpuAddr(cpuAddr), .cpuWrEn(cpuWrEn),
      .cpuRdEn(cpuRdEn), .cpuWrData(cpuWrData));
   blsfm_liu_status i_blsfm_liu_status (.core_clk(core_clk),
      .sys_rst(sys_rst), .clkEn(clkEn), .cpuAddr(cpuAddr),
      .cpuWrEn(cpuWrEn), .cpuRdEn(cpuRdEn), .cpuWrData(cpuWrData),
      .cpuRdData(cpuRdData), .cpuRdValid(cpuRdValid), .txOpenDet(det[2]),
      .txShortDet(det[1]), .rxAbsentDet(det[0]), .rxFailDet(det[5]),
      .rxOverEqDet(det[4]), .rxUnderEqDet(det[3]), .rxLevelIn(lvl),
      .interruptRequestPin(irq), .rxLowPower(rxS[3]), .rxInReset(rxS[2]),
      .rxRunning(rxS[1]), .rxE1Mode(rxS[0]), .txLowPower(txS[3]),
      .txInReset(txS[2]), .txRunning(txS[1]), .txE1Mode(txS[0]),
      .frameQualCount(qual), .frameSearchRule(rule),
      .autoReframeOn(autoOn), .rxReframePulse(reframe),
      .rxZeroSubstOn(misc[3]), .rxSfMode(misc[2]),
      .rxResyncOofOnly(misc[1]), .rxJapanCrcOn(misc[0]));
   task automatic complete_run;
      $display("Checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] e,
      input logic [7:0] g);
      n_tests++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic wrr(input logic [7:0] a, input logic [7:0] d);
      i_blsfm_host.wr(a, d);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      logic v;
      i_blsfm_host.rd(a, d, v);
      chk("read valid", 8'h01, {7'h00, v});
      chk("read data", e, d);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   initial begin
      repeat (5000) @(posedge core_clk);
      fails++;
      complete_run;
   end
   initial begin
      repeat (10) @(posedge core_clk);
      sys_rst <= 1'b0;
      foreach (rstAddr[k]) rdc(rstAddr[k], 8'h00);
      got = {irq, rxS[3], txS[3], autoOn, qual[3:0]};
      chk("reset outs", 8'h7A, got);
      wrr(8'h1B, 8'hFF);
      rdc(8'h1B, 8'h77);
      for (int i = 0; i < 3; i++) begin
         @(posedge core_clk);
         det[i] <= 1'b1;
         rdc(8'h1A, 8'h01 << i);
         chk("irq set", 8'h01, {7'h00, irq});
         wrr(8'h1A, 8'h00);
         rdc(8'h1A, 8'h01 << i);
         wrr(8'h1A, 8'h01 << i);
         rdc(8'h1A, 8'h00);
         chk("irq clear", 8'h00, {7'h00, irq});
         @(posedge core_clk);
         det[i] <= 1'b0;
         rdc(8'h1A, 8'h10 << i);
         wrr(8'h1A, 8'h10 << i);
      end
      wrr(8'h1B, 8'h00);
      @(posedge core_clk);
      det <= 6'h3F;
      rdc(8'h18, 8'h77);
      rdc(8'h1A, 8'h07);
      chk("irq masked", 8'h00, {7'h00, irq});
      wrr(8'h1B, 8'h02);
      tick(2);
      chk("irq enabled", 8'h01, {7'h00, irq});
      @(posedge core_clk);
      det <= 6'h00;
      wrr(8'h1A, 8'h77);
      rdc(8'h1A, 8'h00);
      for (int l = 0; l < 16; l += 5) begin
         @(posedge core_clk);
         lvl <= 4'(l);
         wrr(8'h19, 8'hFF);
         rdc(8'h19, {4'(l), 4'h0});
      end
      wrr(8'h30, 8'hFF);
      rdc(8'h30, 8'h00);
      // Line type and enable go in before init done, soft reset is pulsed
      for (int c = 0; c < 2; c++) begin
         foreach (mWr[k]) begin
            wrr(8'h20 + 8'(c), mWr[k]);
            tick(2);
            got = c ? {txS, rxS} : {rxS, txS};
            chk("own", mExp[k], got[7:4]);
            chk("other", 8'h08, got[3:0]);
         end
      end
      wrr(8'h21, 8'hFF);
      rdc(8'h21, 8'hC3);
      wrr(8'h20, 8'hC0);
      wrr(8'h22, 8'h80);
      tick(2);
      chk("qual", 8'h18, {3'h0, qual});
      p0 = pulses;
      wrr(8'h22, 8'h0B);
      wrr(8'h22, 8'h0B);
      tick(3);
      got = {qual, rule, autoOn, 1'b0};
      chk("config", 8'h54, got);
      chk("pulses", 8'h01, 8'(pulses - p0));
      wrr(8'h22, 8'h74);
      tick(3);
      chk("ds1 bits", 8'h0F, {4'h0, misc});
      // A write while the clock enable is low must be dropped
      @(posedge core_clk);
      clkEn <= 1'b0;
      wrr(8'h1B, 8'h77);
      @(posedge core_clk);
      clkEn <= 1'b1;
      rdc(8'h1B, 8'h02);
      complete_run;
   end
endmodule
`default_nettype wire
